/* design/scgc_pkg.sv */
// constants shared by the serializer configuration/gpio device and its controller
// Function
// - controller writes new address to owning device first
// - then copies same address to other device
// - resolve both config straps to low, mid, high
// - lock set: every register write ignored
// - lock clears only on power loss or power-down
// - gpio enable forces shared input low
// - output 0 pulls low, 1 leaves undriven
// - enabled gpio inputs sampled into read-only register
// - control-channel enable low gives pins config roles
// - pin configuration latched at power-up and again after each power-down
// - enable high: mode strap picks base/bypass
// - enable low: width strap picks 24/32 bit
// - enable low: strap enables sync encoding
// - enable low: strap enables error correction
// - enable low: strap picks single/double input
// - controller turns off features deserializer lacks
// - no i2c forwarding: controller uses uart modes
// - channel rate at most 1M uart, 400k i2c
// - lock is bit 0, covers 0x00-0x1f
// - device addresses sit in bits 7:1
package scgc_pkg;
  // device register map
  localparam logic [7:0] SER_ADDR_REG   = 8'h00;
  localparam logic [7:0] DES_ADDR_REG   = 8'h01;
  localparam logic [7:0] GPIO_EN_REG    = 8'h0e;
  localparam logic [7:0] GPIO_OUT_REG   = 8'h0f;
  localparam logic [7:0] GPIO_IN_REG    = 8'h10;
  localparam logic [7:0] LOCK_RANGE_END = 8'h1f;
  localparam logic [7:0] FEAT_REG       = 8'h07;
  localparam int         LOCK_BIT       = 0;
  localparam int         ADDR_LSB       = 1;
  localparam int         FEAT_CRC_BIT   = 0;
  localparam int         FEAT_HAM_BIT   = 1;
  localparam int         FEAT_SYNC_BIT  = 2;
  localparam logic [7:0] SER_ADDR_RST   = 8'h80;
  localparam logic [7:0] DES_ADDR_RST   = 8'h90;
  localparam int         GPIO_N         = 5;
  localparam logic [4:0] GPIO_EN_RST    = 5'h00;
  localparam logic [4:0] GPIO_OUT_RST   = 5'h1f;
  localparam logic [1:0] STRAP_SETTLE   = 2'h2;
  // three-level strap codes
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_MID  = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  // controller software port
  localparam logic [2:0] H_TADDR  = 3'h0;
  localparam logic [2:0] H_TDATA  = 3'h1;
  localparam logic [2:0] H_CTRL   = 3'h2;
  localparam logic [2:0] H_STATUS = 3'h3;
  localparam logic [2:0] H_RDATA  = 3'h4;
  localparam logic [2:0] H_COMPAT = 3'h5;
  localparam logic [2:0] H_CHAN   = 3'h6;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_ADDR  = 2'h3;
  localparam int         CTRL_TGT_BIT = 2;
  // compat bits: set means deserializer lacks the feature
  localparam int         CMP_CRC  = 0;
  localparam int         CMP_HAM  = 1;
  localparam int         CMP_SYNC = 2;
  localparam int         CMP_I2C  = 3;
  // channel rate codes
  localparam logic [1:0] RATE_100K = 2'h0;
  localparam logic [1:0] RATE_400K = 2'h1;
  localparam logic [1:0] RATE_1M   = 2'h2;
endpackage

/* design/scgc_link_if.sv */
// register link between controller and serializer configuration block
`timescale 1ns/1ps
`default_nettype none
interface scgc_link_if;
  logic       tgt;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       we;
  logic       re;
  logic [7:0] rdata;
  modport dev_mp  (input tgt, addr, wdata, we, re, output rdata);
  modport host_mp (output tgt, addr, wdata, we, re, input rdata);
endinterface
`default_nettype wire

/* design/scgc_device.sv */
// serializer configuration, write lock, straps and open-drain gpios
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module scgc_device (
  input  wire logic                       mclk_i,
  input  wire logic                       rstn_i,
  scgc_link_if.dev_mp                     link,
  input  wire logic                       power_down_n_i,
  input  wire logic [1:0]                 config_strap_high_i,
  input  wire logic [1:0]                 config_strap_low_i,
  input  wire logic                       local_control_channel_enable_i,
  input  wire logic                       mode_select_strap_i,
  input  wire logic                       bus_width_select_i,
  input  wire logic                       error_correction_enable_i,
  input  wire logic                       double_input_select_i,
  input  wire logic [scgc_pkg::GPIO_N-1:0] gpio_in_i,
  output logic [scgc_pkg::GPIO_N-1:0]      gpio_out_o,
  output logic [scgc_pkg::GPIO_N-1:0]      gpio_oe_o,
  output logic [scgc_pkg::GPIO_N-1:0]      data_in_force_low_o,
  output logic [1:0]                       config_high_level_o,
  output logic [1:0]                       config_low_level_o,
  output logic                             local_channel_off_o,
  output logic                             bypass_mode_o,
  output logic                             bus_32bit_o,
  output logic                             sync_encoding_enable_o,
  output logic                             error_correction_on_o,
  output logic                             double_input_o,
  output logic                             register_write_lock_o
);
  typedef enum logic [2:0] {
    ST_SETTLE = 3'h1,
    ST_LATCH  = 3'h2,
    ST_RUN    = 3'h4
  } scgc_dstate_type;

  typedef struct packed {
    scgc_dstate_type            st;
    logic [1:0]                 cnt;
    logic [9:0]                 pin_s1;
    logic [9:0]                 pin_s2;
    logic [4:0]                 gin_s1;
    logic [4:0]                 gin_s2;
    logic [1:0]                 pd_s;
    logic [6:0]                 ser_id;
    logic [6:0]                 des_id;
    logic                       lock;
    logic [4:0]                 gpio_en;
    logic [4:0]                 gpio_out;
    logic [4:0]                 gpio_in;
    logic [7:0]                 rdata;
    logic [1:0]                 lvl_hi;
    logic [1:0]                 lvl_lo;
    logic                       lcc_off;
    logic                       bypass;
    logic                       bw32;
    logic                       sync_encoding_enable;
    logic                       edc;
    logic                       double_input_select;
    logic [4:0]                 force_low;
    logic [4:0]                 oe;
  } scgc_dev_type;

  scgc_dev_type q, d;

  // comparator pair from the pad: 11 high, 00 low, otherwise mid
  function automatic logic [1:0] lvl3(input logic [1:0] c);
    if (c == 2'h3) begin
      lvl3 = scgc_pkg::LVL_HIGH;
    end else if (c == 2'h0) begin
      lvl3 = scgc_pkg::LVL_LOW;
    end else begin
      lvl3 = scgc_pkg::LVL_MID;
    end
  endfunction

  logic wr_ok;
  logic hit;

  always_comb begin
    d = q;
    hit = (link.tgt == 1'b0);
    // pins are asynchronous: two flops before anything looks at them
    d.pin_s1 = {config_strap_high_i, config_strap_low_i,
                local_control_channel_enable_i, mode_select_strap_i,
                bus_width_select_i, error_correction_enable_i,
                double_input_select_i, 1'b0};
    d.pin_s2 = q.pin_s1;
    d.gin_s1 = gpio_in_i;
    d.gin_s2 = q.gin_s1;
    d.pd_s = {q.pd_s[0], power_down_n_i};
    // lock blocks 0x00..0x1f, i.e. every register here
    wr_ok = hit && link.we && !q.lock &&
            (link.addr <= scgc_pkg::LOCK_RANGE_END);
    case (q.st)
      ST_SETTLE: begin
        d.cnt = 2'(q.cnt + 2'h1);
        if (q.cnt == scgc_pkg::STRAP_SETTLE) begin
          d.st = ST_LATCH;
        end
      end
      ST_LATCH: begin
        // sampled once per settle; later pin activity is ignored until the next power-down
        d.lvl_hi  = lvl3(q.pin_s2[9:8]);
        d.lvl_lo  = lvl3(q.pin_s2[7:6]);
        d.lcc_off = !q.pin_s2[5];
        if (q.pin_s2[5]) begin
          d.bypass = q.pin_s2[4];
          d.bw32 = 1'b0;
          d.sync_encoding_enable = 1'b0;
          d.edc  = 1'b0;
          d.double_input_select  = 1'b0;
        end else begin
          d.bypass = 1'b0;
          d.bw32 = q.pin_s2[3];
          d.sync_encoding_enable = q.pin_s2[4];
          d.edc  = q.pin_s2[2];
          d.double_input_select  = q.pin_s2[1];
        end
        d.st = ST_RUN;
      end
      ST_RUN: begin
        if (wr_ok) begin
          if (link.addr == scgc_pkg::SER_ADDR_REG) begin
            d.ser_id = link.wdata[7:scgc_pkg::ADDR_LSB];
            d.lock = link.wdata[scgc_pkg::LOCK_BIT];
          end else if (link.addr == scgc_pkg::DES_ADDR_REG) begin
            d.des_id = link.wdata[7:scgc_pkg::ADDR_LSB];
          end else if (link.addr == scgc_pkg::GPIO_EN_REG) begin
            d.gpio_en = link.wdata[4:0];
          end else if (link.addr == scgc_pkg::GPIO_OUT_REG) begin
            d.gpio_out = link.wdata[4:0];
          end
        end
      end
      default: begin
        d.st = ST_SETTLE;
      end
    endcase
    // power-down drops the lock and re-latches the straps
    if (!q.pd_s[1]) begin
      d.lock = 1'b0;
      d.st = ST_SETTLE;
      d.cnt = 2'h0;
    end
    // enabled pin grounds the shared input
    d.force_low = q.gpio_en;
    // open drain: only a 0 drives
    d.oe = q.gpio_en & ~q.gpio_out;
    // input buffer follows enable
    d.gpio_in = q.gin_s2 & q.gpio_en;
    // reads keep working while locked
    d.rdata = 8'h00;
    if (hit && link.re) begin
      if (link.addr == scgc_pkg::SER_ADDR_REG) begin
        d.rdata = {q.ser_id, q.lock};
      end else if (link.addr == scgc_pkg::DES_ADDR_REG) begin
        d.rdata = {q.des_id, 1'b0};
      end else if (link.addr == scgc_pkg::GPIO_EN_REG) begin
        d.rdata = {3'h0, q.gpio_en};
      end else if (link.addr == scgc_pkg::GPIO_OUT_REG) begin
        d.rdata = {3'h0, q.gpio_out};
      end else if (link.addr == scgc_pkg::GPIO_IN_REG) begin
        d.rdata = {3'h0, q.gpio_in};
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.st <= ST_SETTLE;
      q.ser_id <= scgc_pkg::SER_ADDR_RST[7:1];
      q.des_id <= scgc_pkg::DES_ADDR_RST[7:1];
      q.gpio_en <= scgc_pkg::GPIO_EN_RST;
      q.gpio_out <= scgc_pkg::GPIO_OUT_RST;
      q.pd_s <= 2'h3;
      q.lcc_off <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // pads never drive high; the pull-up does
  assign gpio_out_o             = '0;
  assign gpio_oe_o              = q.oe;
  assign data_in_force_low_o    = q.force_low;
  assign config_high_level_o    = q.lvl_hi;
  assign config_low_level_o     = q.lvl_lo;
  assign local_channel_off_o    = q.lcc_off;
  assign bypass_mode_o          = q.bypass;
  assign bus_32bit_o            = q.bw32;
  assign sync_encoding_enable_o = q.sync_encoding_enable;
  assign error_correction_on_o  = q.edc;
  assign double_input_o         = q.double_input_select;
  assign register_write_lock_o  = q.lock;
  assign link.rdata             = q.rdata;
endmodule // scgc_device
`default_nettype wire

/* design/scgc_host.sv */
// controller end: issues register accesses and address-change sequences
`timescale 1ns/1ps
`default_nettype none
module scgc_host (
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  scgc_link_if.host_mp    link,
  input  wire logic [2:0] sw_addr_i,
  input  wire logic [7:0] sw_wdata_i,
  input  wire logic       sw_we_i,
  input  wire logic       sw_re_i,
  output logic [7:0]      sw_rdata_o,
  output logic            chan_i2c_o,
  output logic [1:0]      chan_rate_o
);
  typedef enum logic [3:0] {
    HS_IDLE   = 4'h1,
    HS_WAIT   = 4'h2,
    HS_SECOND = 4'h4,
    HS_DONE   = 4'h8
  } scgc_hstate_type;

  typedef struct packed {
    scgc_hstate_type st;
    logic [7:0]      taddr;
    logic [7:0]      tdata;
    logic [7:0]      rdata;
    logic [3:0]      compat;
    logic            i2c_req;
    logic [1:0]      rate_req;
    logic            tgt;
    logic [7:0]      addr;
    logic [7:0]      wdata;
    logic            we;
    logic            re;
    logic [7:0]      sw_rdata;
    logic            i2c;
    logic [1:0]      rate;
    logic            rd_pend;
  } scgc_host_type;

  scgc_host_type q, d;
  logic [1:0] op;
  logic       ctgt;
  logic [7:0] wd;

  always_comb begin
    d = q;
    d.we = 1'b0;
    d.re = 1'b0;
    op = sw_wdata_i[1:0];
    ctgt = sw_wdata_i[scgc_pkg::CTRL_TGT_BIT];
    // clear features the far end cannot decode
    wd = q.tdata;
    if (q.taddr == scgc_pkg::FEAT_REG) begin
      wd[scgc_pkg::FEAT_CRC_BIT] = q.tdata[scgc_pkg::FEAT_CRC_BIT] &
                                   !q.compat[scgc_pkg::CMP_CRC];
      wd[scgc_pkg::FEAT_HAM_BIT] = q.tdata[scgc_pkg::FEAT_HAM_BIT] &
                                   !q.compat[scgc_pkg::CMP_HAM];
      wd[scgc_pkg::FEAT_SYNC_BIT] = q.tdata[scgc_pkg::FEAT_SYNC_BIT] &
                                    !q.compat[scgc_pkg::CMP_SYNC];
    end
    if (sw_we_i) begin
      if (sw_addr_i == scgc_pkg::H_TADDR) begin
        d.taddr = sw_wdata_i;
      end else if (sw_addr_i == scgc_pkg::H_TDATA) begin
        d.tdata = sw_wdata_i;
      end else if (sw_addr_i == scgc_pkg::H_COMPAT) begin
        d.compat = sw_wdata_i[3:0];
      end else if (sw_addr_i == scgc_pkg::H_CHAN) begin
        d.i2c_req = sw_wdata_i[2];
        d.rate_req = sw_wdata_i[1:0];
      end
    end
    // forwarding falls back to uart when the far end lacks it
    d.i2c = q.i2c_req && !q.compat[scgc_pkg::CMP_I2C];
    // clamp: 400k in i2c, 1M in uart
    if (d.i2c && q.rate_req > scgc_pkg::RATE_400K) begin
      d.rate = scgc_pkg::RATE_400K;
    end else if (q.rate_req > scgc_pkg::RATE_1M) begin
      d.rate = scgc_pkg::RATE_1M;
    end else begin
      d.rate = q.rate_req;
    end
    case (q.st)
      HS_IDLE: begin
        // commands while busy are dropped
        if (sw_we_i && sw_addr_i == scgc_pkg::H_CTRL) begin
          if (op == scgc_pkg::OP_WRITE) begin
            d.tgt = ctgt;
            d.addr = q.taddr;
            d.wdata = ctgt ? q.tdata : wd;
            d.we = 1'b1;
            d.st = HS_DONE;
          end else if (op == scgc_pkg::OP_READ) begin
            d.tgt = ctgt;
            d.addr = q.taddr;
            d.re = 1'b1;
            d.st = HS_WAIT;
          end else if (op == scgc_pkg::OP_ADDR) begin
            // owning device first: tgt 0 serializer, 1 deserializer
            d.tgt = ctgt;
            d.addr = ctgt ? scgc_pkg::DES_ADDR_REG : scgc_pkg::SER_ADDR_REG;
            d.wdata = {q.tdata[7:1], 1'b0};
            d.we = 1'b1;
            d.st = HS_SECOND;
          end
        end
      end
      HS_WAIT: begin
        d.st = HS_DONE;
      end
      HS_SECOND: begin
        // same register, same value, other end of the link
        d.tgt = !q.tgt;
        d.we = 1'b1;
        d.st = HS_DONE;
      end
      HS_DONE: begin
        d.st = HS_IDLE;
      end
      default: begin
        d.st = HS_IDLE;
      end
    endcase
    // device answers the cycle after re, so capture one edge later
    d.rd_pend = q.re;
    if (q.rd_pend) begin
      d.rdata = link.rdata;
    end
    d.sw_rdata = 8'h00;
    if (sw_re_i) begin
      if (sw_addr_i == scgc_pkg::H_TADDR) begin
        d.sw_rdata = q.taddr;
      end else if (sw_addr_i == scgc_pkg::H_TDATA) begin
        d.sw_rdata = q.tdata;
      end else if (sw_addr_i == scgc_pkg::H_STATUS) begin
        d.sw_rdata = {7'h00, q.st != HS_IDLE};
      end else if (sw_addr_i == scgc_pkg::H_RDATA) begin
        d.sw_rdata = q.rdata;
      end else if (sw_addr_i == scgc_pkg::H_COMPAT) begin
        d.sw_rdata = {4'h0, q.compat};
      end else if (sw_addr_i == scgc_pkg::H_CHAN) begin
        d.sw_rdata = {4'h0, q.i2c, q.i2c_req, q.rate};
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.st <= HS_IDLE;
    end else begin
      q <= d;
    end
  end

  assign link.tgt    = q.tgt;
  assign link.addr   = q.addr;
  assign link.wdata  = q.wdata;
  assign link.we     = q.we;
  assign link.re     = q.re;
  assign sw_rdata_o  = q.sw_rdata;
  assign chan_i2c_o  = q.i2c;
  assign chan_rate_o = q.rate;
endmodule // scgc_host
`default_nettype wire

/* testbench/scgc_link_props.sv */
// assertions on the register link between controller and device
`timescale 1ns/1ps
`default_nettype none
module scgc_link_props (
  input wire logic       mclk_i,
  input wire logic       rstn_i,
  input wire logic       tgt,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       we,
  input wire logic       re,
  input wire logic [7:0] rdata
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  // back-to-back writes only come from an address change
  strobe_excl_a: assert property (!(we && re))
    else $error("link write and read strobes together");
  rdata_idle_a: assert property (!$past(re) |-> rdata == 8'h00)
    else $error("link read data not idle");
  read_pulse_a: assert property (re |=> !re)
    else $error("link read strobe too long");
  addr_copy_a: assert property (we && $past(we) |->
    wdata == $past(wdata) && addr == $past(addr) && tgt != $past(tgt))
    else $error("address copy differs");
  addr_order_a: assert property (we && $past(we) |->
    $past(tgt) == addr[0] && addr[7:1] == 7'h00)
    else $error("address change in wrong order");
  addr_field_a: assert property (we && $past(we) |-> !wdata[0])
    else $error("address change touches bit 0");
  des_resv_a: assert property (re && !tgt && addr == 8'h01
    |=> !rdata[0])
    else $error("reserved bit of address reads set");
  gpio_width_a: assert property (re && !tgt && addr == 8'h10
    |=> rdata[7:5] == 3'h0)
    else $error("gpio input state too wide");
  unmapped_a: assert property (re && !tgt && addr > 8'h1f
    |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  cover property (we && $past(we));
  cover property (re && !tgt && addr == 8'h00 ##1 rdata[0]);
  cover property (re && !tgt && addr == 8'h10 ##1 rdata != 8'h00);
endmodule // scgc_link_props
`default_nettype wire

/* testbench/tb_serializer_config_gpio_control.sv */
// self-checking bench: controller and device joined over the link
`timescale 1ns/1ps
`default_nettype none
module tb_serializer_config_gpio_control;
  logic        mclk_i, rstn_i, pd_n, lcc, ms, bus_width_select, ecc, double_input_select, swe, sre;
  logic [1:0]  cfh, cfl, lvh, lvl, crate;
  logic [4:0]  gin, gout, goe, flow;
  logic [2:0]  sa;
  logic [7:0]  sd, srd, t, fw, e1, e2;
  logic        ci2c, loff, byp, b32, syn, eco, dbo, lko;
  logic [31:0] rs;
  int          err_total, cmp_count, lk;
  int          mdl[32];
  scgc_link_if link();
  scgc_device u_scgc_device (.mclk_i(mclk_i), .rstn_i(rstn_i), .link(link),
    .power_down_n_i(pd_n), .config_strap_high_i(cfh),
    .config_strap_low_i(cfl), .local_control_channel_enable_i(lcc),
    .mode_select_strap_i(ms), .bus_width_select_i(bus_width_select),
    .error_correction_enable_i(ecc), .double_input_select_i(double_input_select),
    .gpio_in_i(gin), .gpio_out_o(gout), .gpio_oe_o(goe),
    .data_in_force_low_o(flow), .config_high_level_o(lvh),
    .config_low_level_o(lvl), .local_channel_off_o(loff),
    .bypass_mode_o(byp), .bus_32bit_o(b32), .sync_encoding_enable_o(syn),
    .error_correction_on_o(eco), .double_input_o(dbo),
    .register_write_lock_o(lko));
  scgc_host u_scgc_host (.mclk_i(mclk_i), .rstn_i(rstn_i), .link(link),
    .sw_addr_i(sa), .sw_wdata_i(sd), .sw_we_i(swe), .sw_re_i(sre),
    .sw_rdata_o(srd), .chan_i2c_o(ci2c), .chan_rate_o(crate));
  scgc_link_props u_scgc_link_props (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .tgt(link.tgt), .addr(link.addr), .wdata(link.wdata), .we(link.we),
    .re(link.re), .rdata(link.rdata));
  // feature writes seen on the wire
  always @(posedge mclk_i)
    if (link.we && !link.tgt && link.addr == 8'h07) fw <= link.wdata;
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [1:0] lv(input logic [1:0] c);
    return c == 2'h3 ? scgc_pkg::LVL_HIGH :
           c == 2'h0 ? scgc_pkg::LVL_LOW : scgc_pkg::LVL_MID;
  endfunction
  function automatic logic [7:0] exp_rd(input int a);
    if (a == 16) return {3'h0, gin & 5'(mdl[14])};
    if (a == 0 || a == 1 || a == 14 || a == 15) return 8'(mdl[a]);
    return 8'h00;
  endfunction
  // model drops every write once locked
  function automatic void mwr(input int a, input logic [7:0] d);
    if (lk != 0 || a > 31) return;
    if (a == 0) lk = d[0];
    mdl[a] = a == 1 ? d & 8'hfe : (a == 14 || a == 15) ? d & 8'h1f : d;
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic sw_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    sa <= a;
    sd <= d;
    swe <= 1'b1;
    @(posedge mclk_i);
    swe <= 1'b0;
  endtask
  task automatic sw_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    sa <= a;
    sre <= 1'b1;
    @(posedge mclk_i);
    sre <= 1'b0;
    @(negedge mclk_i);
    d = srd;
  endtask
  task automatic op(input logic [7:0] c, input int a, input logic [7:0] d);
    logic [7:0] s;
    sw_wr(scgc_pkg::H_TADDR, 8'(a));
    sw_wr(scgc_pkg::H_TDATA, d);
    sw_wr(scgc_pkg::H_CTRL, c);
    for (int i = 0; i < 20; i++) begin
      sw_rd(scgc_pkg::H_STATUS, s);
      if (s[0] === 1'b0) return;
    end
    err_total++;
    $display("wrong value at %0t: controller stays busy", $time);
    report_and_stop();
  endtask
  task automatic wr(input int a, input logic [7:0] d);
    op(8'h01, a, d);
    mwr(a, d);
  endtask
  task automatic rd_chk(input int a);
    op(8'h02, a, 8'h00);
    sw_rd(scgc_pkg::H_RDATA, t);
    chk(t, exp_rd(a));
  endtask
  // power-down clears the lock and latches the pins again
  task automatic pwr();
    @(posedge mclk_i);
    pd_n <= 1'b0;
    repeat (4) @(posedge mclk_i);
    pd_n <= 1'b1;
    repeat (12) @(posedge mclk_i);
    lk = 0;
    mdl[0] = mdl[0] & 8'hfe;
  endtask
  task automatic settle();
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask
  initial begin
    {pd_n, lcc, ms, bus_width_select, ecc, double_input_select, swe, sre} = 8'h80;
    {cfh, cfl, gin, sa, sd} = '0;
    rstn_i = 1'b0;
    rs = 32'h3edc;
    err_total = 0;
    cmp_count = 0;
    lk = 0;
    foreach (mdl[i]) mdl[i] = 0;
    mdl[0] = 8'h80;
    mdl[1] = 8'h90;
    mdl[15] = 8'h1f;
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    for (int a = 0; a < 2; a++) rd_chk(a);
    rd_chk(15);
    rd_chk(8'h20);
    $display("test reset values done");
    for (int k = 0; k < 4; k++) begin
      rs = lfsr(rs);
      @(posedge mclk_i);
      {ms, bus_width_select, ecc, double_input_select, cfh, cfl} <= rs[7:0];
      lcc <= k[0];
      pwr();
      e1 = {2'h0, !lcc, lcc & ms, !lcc & bus_width_select, !lcc & ms, !lcc & ecc,
            !lcc & double_input_select};
      e2 = {4'h0, lv(cfh), lv(cfl)};
      {lcc, ms, bus_width_select, ecc, double_input_select, cfh, cfl} <= ~{lcc, ms, bus_width_select, ecc, double_input_select, cfh, cfl};
      settle();
      chk({2'h0, loff, byp, b32, syn, eco, dbo}, e1);
      chk({4'h0, lvh, lvl}, e2);
    end
    $display("test straps done");
    for (int k = 0; k < 3; k++) begin
      rs = lfsr(rs);
      @(posedge mclk_i);
      gin <= rs[4:0];
      wr(14, rs[15:8]);
      wr(15, rs[23:16]);
      settle();
      chk(8'(flow), 8'(mdl[14]));
      chk(8'(goe), 8'(mdl[14] & ~mdl[15] & 31));
      chk(8'(gout), 8'h00);
      rd_chk(16);
      rd_chk(15);
    end
    $display("test gpio done");
    rs = lfsr(rs);
    op(8'h03, 0, rs[7:0]);
    mwr(0, rs[7:0] & 8'hfe);
    rd_chk(0);
    op(8'h07, 0, rs[15:8]);
    mwr(1, rs[15:8]);
    rd_chk(1);
    $display("test address change done");
    wr(0, 8'h41);
    settle();
    chk(8'(lko), 8'h01);
    wr(14, 8'h15);
    wr(0, 8'h40);
    op(8'h03, 0, 8'h22);
    settle();
    chk(8'(lko), 8'h01);
    chk(8'(flow), 8'(mdl[14]));
    rd_chk(0);
    rd_chk(14);
    pwr();
    settle();
    chk(8'(lko), 8'h00);
    rd_chk(0);
    $display("test lock done");
    sw_wr(scgc_pkg::H_COMPAT, 8'h0d);
    sw_wr(scgc_pkg::H_CHAN, 8'h07);
    settle();
    chk({5'h0, ci2c, crate}, 8'h02);
    wr(7, 8'hff);
    chk(fw, 8'hfa);
    sw_wr(scgc_pkg::H_COMPAT, 8'h00);
    sw_wr(scgc_pkg::H_CHAN, 8'h06);
    settle();
    chk({5'h0, ci2c, crate}, 8'h05);
    sw_rd(scgc_pkg::H_CHAN, t);
    chk(t, 8'h0d);
    $display("test control channel done");
    report_and_stop();
  end
endmodule // tb_serializer_config_gpio_control
`default_nettype wire
